// ---- src/sync_sram_pkg.sv ----
package sync_sram_pkg;

  // array geometry: 36-bit word as four 9-bit lanes (8 data + 1 parity)
  localparam int ADDR_W      = 8;
  localparam int LANE_N      = 4;
  localparam int LANE_DATA_W = 8;
  localparam int DATA_W      = LANE_N * LANE_DATA_W;
  localparam int PAR_W       = LANE_N;
  localparam int DEPTH       = 1 << ADDR_W;
  localparam int BURST_W     = 2;

  // burst-order strap levels
  localparam logic ORDER_LINEAR      = 1'b0;
  localparam logic ORDER_INTERLEAVED = 1'b1;

  // sleep entry and exit latency, in clock cycles
  localparam int SLEEP_CYCLES = 2;

  // one registered set of synchronous controls
  typedef struct packed {
    logic                cpu_addr_strobe_n;
    logic                ctrl_addr_strobe_n;
    logic                burst_step_n;
    logic                global_write_n;
    logic                byte_write_gate_n;
    logic [LANE_N-1:0]   byte_lane_select_n;
    logic                chip_sel_primary_n;
    logic                chip_sel_high;
    logic                chip_sel_low_n;
    logic [ADDR_W-1:0]   addr;
  } ctrl_in_t;

  // one array word: data plus parity bits
  typedef struct packed {
    logic [PAR_W-1:0]  parity;
    logic [DATA_W-1:0] data;
  } word_t;

endpackage

// ---- src/sync_burst_sram.sv ----
`timescale 1ns/100ps
module sync_burst_sram
  import sync_sram_pkg::*;
(
  // clock and reset
  input  wire logic                  i_sys_clk,
  input  wire logic                  i_srst,
  // synchronous controls
  input  wire logic                  i_cpu_addr_strobe_n,
  input  wire logic                  i_ctrl_addr_strobe_n,
  input  wire logic                  i_burst_step_n,
  input  wire logic                  i_global_write_n,
  input  wire logic                  i_byte_write_gate_n,
  input  wire logic [LANE_N-1:0]     i_byte_lane_select_n,
  input  wire logic                  i_chip_sel_primary_n,
  input  wire logic                  i_chip_sel_high,
  input  wire logic                  i_chip_sel_low_n,
  input  wire logic [ADDR_W-1:0]     i_addr,
  // asynchronous pins, passed through two-flop synchronisers
  input  wire logic                  i_output_enable_n,
  input  wire logic                  i_sleep_request,
  input  wire logic                  i_burst_order,
  // data and parity lines as three signals each
  input  wire logic [DATA_W-1:0]     i_data_io,
  input  wire logic [PAR_W-1:0]      i_parity_io,
  output logic      [DATA_W-1:0]     o_data_io,
  output logic      [PAR_W-1:0]      o_parity_io,
  output logic      [DATA_W-1:0]     o_data_io_oe,
  output logic      [PAR_W-1:0]      o_parity_io_oe,
  // status
  output logic                       o_sleeping
);

  // burst next-address function
  function automatic logic [BURST_W-1:0] burst_addr(input logic [BURST_W-1:0] start,
                                                    input logic [BURST_W-1:0] step,
                                                    input logic               ilv);
    burst_addr = ilv ? (start ^ step) : BURST_W'(start + step);
  endfunction

  typedef enum logic [1:0] {IDLE, READ, WR_PEND} acc_state_t;

  // registered pins
  ctrl_in_t            in_ff;
  word_t               din_ff;

  // synchroniser stages of the asynchronous pins
  logic                oe_s1_ff;
  logic                oe_s2_ff;
  logic                zz_s1_ff;
  logic                zz_s2_ff;
  logic                mode_s1_ff;
  logic                mode_s2_ff;

  // strap and sleep control
  logic                order_ff;
  logic [1:0]          zz_cnt_ff;
  logic                sleep_ff;

  // access control and burst counter
  acc_state_t          state_ff;
  logic                selected_ff;
  logic [ADDR_W-1:0]   base_ff;
  logic [BURST_W-1:0]  start_ff;
  logic [BURST_W-1:0]  step_ff;

  // output stage
  word_t               q_ff;
  logic                qvalid_ff;
  logic                fresh_ff;
  logic                first_ff;

  // storage array
  word_t               mem [DEPTH];

  // control input register
  always_ff @(posedge i_sys_clk) begin
    in_ff      <= '{i_cpu_addr_strobe_n, i_ctrl_addr_strobe_n, i_burst_step_n,
                    i_global_write_n, i_byte_write_gate_n, i_byte_lane_select_n,
                    i_chip_sel_primary_n, i_chip_sel_high, i_chip_sel_low_n, i_addr};
  end

  // write data register, aligned with the registered controls
  always_ff @(posedge i_sys_clk) begin
    din_ff     <= '{i_parity_io, i_data_io};
  end

  // output enable synchroniser
  always_ff @(posedge i_sys_clk) begin
    oe_s1_ff   <= i_output_enable_n;
    oe_s2_ff   <= oe_s1_ff;
  end

  // sleep synchroniser
  always_ff @(posedge i_sys_clk) begin
    zz_s1_ff   <= i_sleep_request;  // pull-down lives in the pad
    zz_s2_ff   <= zz_s1_ff;
  end

  // strap synchroniser
  always_ff @(posedge i_sys_clk) begin
    mode_s1_ff <= i_burst_order;
    mode_s2_ff <= mode_s1_ff;
  end

  // strap sampled whenever idle and deselected; reset loads interleaved
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      order_ff <= ORDER_INTERLEAVED;
    end else if (state_ff == IDLE && !selected_ff) begin
      order_ff <= mode_s2_ff;
    end
  end

  // sleep latency counter, restarts whenever the request matches the state
  always_ff @(posedge i_sys_clk) begin
    if (i_srst || zz_s2_ff == sleep_ff || zz_cnt_ff == 2'(SLEEP_CYCLES - 1)) begin
      zz_cnt_ff <= 2'h0;
    end else begin
      zz_cnt_ff <= zz_cnt_ff + 2'h1;
    end
  end

  // sleep flag follows the request after two cycles
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      sleep_ff  <= 1'b0;
    end else if (zz_s2_ff != sleep_ff && zz_cnt_ff == 2'(SLEEP_CYCLES - 1)) begin
      sleep_ff  <= zz_s2_ff;
    end
  end

  // decode of the registered controls
  logic                sel_ok;
  logic                cpu_go;
  logic                ctl_go;
  logic                start_go;
  logic                deselect;
  logic                cont;
  logic                wr_ctl;
  logic                any_wr;
  logic [LANE_N-1:0]   lanes;
  logic [ADDR_W-1:0]   cur_addr;
  always_comb begin
    // strobe and chip-enable qualification
    sel_ok   = !in_ff.chip_sel_primary_n && in_ff.chip_sel_high
               && !in_ff.chip_sel_low_n;
    cpu_go   = !in_ff.cpu_addr_strobe_n && sel_ok;
    ctl_go   = in_ff.cpu_addr_strobe_n && !in_ff.ctrl_addr_strobe_n && sel_ok;
    start_go = cpu_go || ctl_go;  // new external address
    deselect = (!in_ff.cpu_addr_strobe_n && !in_ff.chip_sel_primary_n && !sel_ok)
               || (!in_ff.ctrl_addr_strobe_n && !sel_ok
                   && (in_ff.cpu_addr_strobe_n || in_ff.chip_sel_primary_n));
    cont     = in_ff.ctrl_addr_strobe_n
               && (in_ff.cpu_addr_strobe_n || in_ff.chip_sel_primary_n);
    // global write overrides lane selects
    lanes    = !in_ff.global_write_n ? {LANE_N{1'b1}} :
               (!in_ff.byte_write_gate_n ? ~in_ff.byte_lane_select_n : '0);
    wr_ctl   = !in_ff.global_write_n || !in_ff.byte_write_gate_n;
    any_wr   = lanes != '0;
    // current word address from the burst counter
    cur_addr = {base_ff[ADDR_W-1:BURST_W], burst_addr(start_ff, step_ff, order_ff)};
  end

  // address register and burst counter
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      base_ff     <= '0;
      start_ff    <= '0;
      step_ff     <= '0;
    end else if (!sleep_ff && start_go) begin
      base_ff     <= in_ff.addr;  // advance ignored; write controls ignored on a cpu-strobe start
      start_ff    <= in_ff.addr[BURST_W-1:0];
      step_ff     <= '0;
    end else if (!sleep_ff && !deselect && cont && selected_ff
                 && !in_ff.burst_step_n && state_ff != WR_PEND) begin
      step_ff     <= step_ff + 2'h1;  // advance high holds the address
    end
  end

  // access state; a pending access is dropped in sleep
  always_ff @(posedge i_sys_clk) begin
    if (i_srst || sleep_ff) begin
      state_ff    <= IDLE;
    end else if (cpu_go) begin
      state_ff    <= WR_PEND;     // read or write decided next edge
    end else if (ctl_go) begin
      state_ff    <= wr_ctl ? IDLE : READ;  // one-cycle write
    end else if (deselect) begin
      state_ff    <= IDLE;
    end else if (cont && selected_ff) begin
      state_ff    <= wr_ctl ? IDLE : READ;
    end
  end

  // selection flag, set by a start and cleared by deselect or sleep
  always_ff @(posedge i_sys_clk) begin
    if (i_srst || sleep_ff) begin
      selected_ff <= 1'b0;
    end else if (start_go) begin
      selected_ff <= 1'b1;
    end else if (deselect) begin
      selected_ff <= 1'b0;
    end
  end

  // array write and read
  logic wr_now;
  logic [ADDR_W-1:0] wr_addr;
  always_comb begin
    wr_now  = !sleep_ff && any_wr && ((ctl_go)
              || (state_ff == WR_PEND && !cpu_go && !ctl_go && !deselect)
              || (cont && selected_ff && state_ff != WR_PEND));
    wr_addr = ctl_go ? in_ff.addr : cur_addr;
  end

  // byte-lane write into the array
  always_ff @(posedge i_sys_clk) begin
    if (wr_now) begin
      for (int l = 0; l < LANE_N; l++) begin
        if (lanes[l]) begin
          mem[wr_addr].data[l*LANE_DATA_W +: LANE_DATA_W] <=
            din_ff.data[l*LANE_DATA_W +: LANE_DATA_W];
          mem[wr_addr].parity[l] <= din_ff.parity[l];
        end
      end
    end
  end

  // output register loads the word of the prior address
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      q_ff      <= '0;
    end else begin
      q_ff      <= mem[cur_addr];
    end
  end

  // output word valid while selected and not writing
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      qvalid_ff <= 1'b0;
    end else begin
      qvalid_ff <= !sleep_ff && selected_ff && !wr_now && !deselect;
    end
  end

  // first word after leaving deselect stays floating
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      fresh_ff  <= 1'b0;
      first_ff  <= 1'b0;
    end else begin
      fresh_ff  <= start_go && !selected_ff;  // start out of deselect seen
      first_ff  <= fresh_ff;                  // lines up with the first word
    end
  end

  // drivers gated by enable, first-cycle mask and write detect
  logic                drive;
  always_comb begin
    drive          = qvalid_ff && !first_ff && !oe_s2_ff && !sleep_ff && !wr_now;
  end

  // line values and enables
  always_comb begin
    o_data_io      = q_ff.data;
    o_parity_io    = q_ff.parity;
    o_data_io_oe   = {DATA_W{drive}};
    o_parity_io_oe = {PAR_W{drive}};
    o_sleeping     = sleep_ff;
  end

endmodule

// ---- testbench/sync_burst_sram_asserts.sv ----
`timescale 1ns/100ps
module sram_chk
  import sync_sram_pkg::*;
(
  // clock, reset and controls
  input wire logic              i_sys_clk, i_srst, i_cpu_addr_strobe_n, i_ctrl_addr_strobe_n,
  input wire logic              i_global_write_n, i_byte_write_gate_n, i_chip_sel_primary_n,
  input wire logic              i_chip_sel_high, i_chip_sel_low_n, i_output_enable_n,
  input wire logic              i_sleep_request,
  // driven side
  input wire logic [DATA_W-1:0] o_data_io_oe,
  input wire logic [PAR_W-1:0]  o_parity_io_oe,
  input wire logic              o_sleeping
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_srst);
  // controller-strobe cycle, device selected, all enables as one vector
  wire logic        cs  = !i_ctrl_addr_strobe_n && i_cpu_addr_strobe_n;
  wire logic        sel = !i_chip_sel_primary_n && i_chip_sel_high && !i_chip_sel_low_n;
  wire logic [35:0] en  = {o_parity_io_oe, o_data_io_oe};
  wire logic        drv = o_data_io_oe[0];
  sequence s_desel; cs && i_chip_sel_primary_n; endsequence
  sequence s_read; cs && sel && i_global_write_n && i_byte_write_gate_n; endsequence
  sequence s_write; cs && sel && !i_global_write_n; endsequence

  a_oe_uniform: assert property ((&en) == (|en))
    else $error("line enables disagree");
  a_oe_off_float: assert property (i_output_enable_n [*4] |-> !drv)
    else $error("driving with output enable high");
  a_sleep_enter: assert property (i_sleep_request [*8] |-> o_sleeping)
    else $error("sleep not entered");
  a_sleep_exit: assert property (!i_sleep_request [*8] |-> !o_sleeping)
    else $error("sleep not left");
  a_sleep_float: assert property (o_sleeping |-> !drv)
    else $error("driving while asleep");
  a_write_float: assert property (s_write |-> ##[1:3] !drv)
    else $error("drivers on during write");
  a_desel_float: assert property (s_desel |-> ##[1:3] !drv)
    else $error("drivers on after deselect");
  a_first_float: assert property (s_desel ##1 s_read |-> ##2 !drv ##1 !drv)
    else $error("first access after deselect driven");
endmodule

bind sync_burst_sram sram_chk chk (.*);

// ---- testbench/bus_partner.sv ----
`timescale 1ns/100ps
module bus_partner
  import sync_sram_pkg::*;
(
  // clock, reset, controller offer and device side
  input  wire logic  i_sys_clk, i_srst, i_drive, i_dev_oe,
  input  wire word_t i_wdata, i_dev_q,
  // resolved lines and sticky two-driver flag
  output word_t      o_wire,
  output logic       o_clash
);
  word_t last_ff;
  // released lines show the inverse of their last level, so they toggle every cycle while neither end drives
  always_comb begin
    if (i_dev_oe)
      o_wire = i_dev_q;
    else if (i_drive)
      o_wire = i_wdata;
    else
      o_wire = ~last_ff;
  end
  // remember the level and note any cycle where both ends drive
  always_ff @(posedge i_sys_clk) begin
    last_ff <= i_srst ? '0 : o_wire;
    o_clash <= i_srst ? 1'h0 : (o_clash | (i_drive & i_dev_oe));
  end
endmodule

// ---- testbench/pipelined_sync_burst_sram_access_test.sv ----
`timescale 1ns/100ps
module pipelined_sync_burst_sram_access_test;
  import sync_sram_pkg::*;
  // idle, deselect and advance control sets
  localparam ctrl_in_t IDLE  = '{1'h1,1'h1,1'h1,1'h1,1'h1,4'hF,1'h1,1'h0,1'h1,8'h00};
  localparam ctrl_in_t DESEL = '{1'h1,1'h0,1'h1,1'h1,1'h1,4'hF,1'h1,1'h0,1'h1,8'h00};
  localparam ctrl_in_t STEP  = '{1'h1,1'h1,1'h0,1'h1,1'h1,4'hF,1'h1,1'h0,1'h1,8'h00};
  logic              i_sys_clk = 1'h0, i_srst = 1'h1, oe_n = 1'h0, sleep_rq = 1'h0;
  logic              order = 1'h1, drive = 1'h0, slp, clash;
  logic [DATA_W-1:0] d_oe;
  logic [PAR_W-1:0]  p_oe;
  ctrl_in_t          c = IDLE;
  word_t             wd = '0, w, m [DEPTH];
  wire word_t        q;
  int                errors = 0, cmp_count = 0;

  // 10 MHz clock
  always #50 i_sys_clk = ~i_sys_clk;

  // device and far-end bus model
  sync_burst_sram dut (
    .i_sys_clk(i_sys_clk), .i_srst(i_srst), .i_cpu_addr_strobe_n(c.cpu_addr_strobe_n),
    .i_ctrl_addr_strobe_n(c.ctrl_addr_strobe_n), .i_burst_step_n(c.burst_step_n),
    .i_global_write_n(c.global_write_n), .i_byte_write_gate_n(c.byte_write_gate_n),
    .i_byte_lane_select_n(c.byte_lane_select_n), .i_chip_sel_primary_n(c.chip_sel_primary_n),
    .i_chip_sel_high(c.chip_sel_high), .i_chip_sel_low_n(c.chip_sel_low_n), .i_addr(c.addr),
    .i_output_enable_n(oe_n), .i_sleep_request(sleep_rq), .i_burst_order(order),
    .i_data_io(w.data), .i_parity_io(w.parity), .o_data_io(q.data), .o_parity_io(q.parity),
    .o_data_io_oe(d_oe), .o_parity_io_oe(p_oe), .o_sleeping(slp));
  bus_partner far_end (.i_sys_clk(i_sys_clk), .i_srst(i_srst), .i_drive(drive),
    .i_dev_oe(d_oe[0]), .i_wdata(wd), .i_dev_q(q), .o_wire(w), .o_clash(clash));

  // selected start cycle; byte gate low only when some lane is picked
  function automatic ctrl_in_t op(logic p, logic gw, logic [3:0] ln, logic [7:0] a);
    op = '{~p, p, 1'h1, gw, &ln, ln, 1'h0, 1'h1, 1'h0, a};
  endfunction

  task automatic cyc(ctrl_in_t x, logic dr, word_t v);
    @(negedge i_sys_clk);
    c = x;
    drive = dr;
    wd = v;
  endtask

  task automatic check(logic [35:0] seen, logic [35:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // write through either strobe and update the expected array
  task automatic wr(logic p, logic [7:0] a, logic gw, logic [3:0] ln, word_t v);
    ctrl_in_t x;
    x = op(p, gw, ln, a);
    oe_n = 1'h1;
    if (p) begin
      cyc(op(1'h1, 1'h1, 4'hF, a), 1'h0, '0);
      x.cpu_addr_strobe_n = 1'h1;
    end
    cyc(x, 1'h1, v);
    for (int l = 0; l < LANE_N; l++)
      if (!gw || !ln[l]) begin
        m[a].data[8*l +: 8] = v.data[8*l +: 8];
        m[a].parity[l] = v.parity[l];
      end
    cyc(DESEL, 1'h0, '0);
  endtask

  // four-beat burst read; each word shows three calls after its request
  task automatic rd(logic [7:0] a, logic hi);
    oe_n = hi;
    for (int i = 0; i < 7; i++) begin
      cyc(i == 0 ? op(1'h0, 1'h1, 4'hF, a) : (i < 4 ? STEP : IDLE), 1'h0, '0);
      if (i > 2) begin
        check(q, m[{a[7:2], order ? a[1:0] ^ 2'(i-3) : a[1:0] + 2'(i-3)}]);
        check({p_oe, d_oe}, (i == 3 || hi) ? 36'h0 : 36'hF_FFFF_FFFF);
      end
    end
    cyc(DESEL, 1'h0, '0);
    $display("burst from %h done", a);
  endtask

  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // reset, writes, bursts in both orders, output enable high, sleep
  initial begin
    repeat (8) @(negedge i_sys_clk);
    i_srst = 1'h0;
    for (int i = 0; i < 4; i++)
      wr(1'h0, 8'h10 + 8'(i), 1'h0, 4'hF, {4'(i), 32'(32'h1357_9BDF * (i + 1))});
    wr(1'h0, 8'h12, 1'h1, 4'hA, 36'h9_DEAD_BEEF);
    wr(1'h1, 8'h13, 1'h0, 4'hF, 36'h6_CAFE_F00D);
    wr(1'h1, 8'h10, 1'h1, 4'h5, 36'hF_1234_5678);
    $display("writes done");
    rd(8'h11, 1'h0);
    rd(8'h12, 1'h1);
    order = 1'h0;
    repeat (4) cyc(DESEL, 1'h0, '0);
    rd(8'h13, 1'h0);
    sleep_rq = 1'h1;
    repeat (8) cyc(IDLE, 1'h0, '0);
    check({35'h0, slp}, 36'h1);
    sleep_rq = 1'h0;
    repeat (8) cyc(IDLE, 1'h0, '0);
    check({35'h0, slp}, 36'h0);
    $display("sleep done");
    rd(8'h10, 1'h0);
    check({35'h0, clash}, 36'h0);
    end_sim();
  end

  // the run needs under a hundred cycles; give it forty times that
  initial begin
    #400_000;
    errors++;
    end_sim();
  end
endmodule
